/* verilog/gate_ctl_regs.svh */
// Purpose: offsets, fields and timing counts of the inverter-side gate controller
// Assumes: 20 MHz clk_sys, APB register access, 32-bit data
// Notes:   definitions only
`ifndef GATE_CTL_REGS_SVH
`define GATE_CTL_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define GC_CTRL_OFS       8'h00
`define GC_PERIOD_OFS     8'h04
`define GC_DUTY_OFS       8'h08
`define GC_DEAD_OFS       8'h0C
`define GC_STATUS_OFS     8'h10
`define GC_IRQ_STAT_OFS   8'h14
`define GC_IRQ_EN_OFS     8'h18
`define GC_IRQ_CLR_OFS    8'h1C
`define GC_TEMP_OFS       8'h20
`define GC_CLEAR_OFS      8'h24

// ****************************************
// control fields
// ****************************************
`define GC_CTRL_RUN       0
`define GC_CTRL_SUPPLY_ON 1
`define GC_CTRL_SW_EN     2
`define GC_CTRL_RESET     8'h00

// ****************************************
// status and interrupt fields
// ****************************************
`define GC_ST_FAULT       0
`define GC_ST_CLEARING    1
`define GC_ST_RUN         2
`define GC_IRQ_FAULT_SET  0
`define GC_IRQ_FAULT_GONE 1
`define GC_IRQ_TEMP       2
`define GC_IRQ_W          3

// ****************************************
// timing
// ****************************************
`define GC_CLK_HZ         20000000
`define GC_CLR_PULSE_NS   500
`define GC_CLR_PULSE_CYC  ((`GC_CLR_PULSE_NS * (`GC_CLK_HZ / 1000000) + 999) / 1000)
`define GC_DEAD_MIN       16'h0001
`define GC_PERIOD_RESET   16'h03E8
`define GC_DUTY_RESET     16'h01F4
`define GC_DEAD_RESET     16'h0014
`define GC_TEMP_GATE_CYC  20000000

`endif

/* verilog/gate_ctl_pkg.sv */
// Purpose: types of the inverter-side gate controller
// Assumes: constants live in gate_ctl_regs.svh
// Notes:   none
package gate_ctl_pkg;

  typedef struct packed {
    logic paddr_ok;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic high_side_cmd_pos;
    logic high_side_cmd_neg;
    logic low_side_cmd_pos;
    logic low_side_cmd_neg;
    logic sw_enable;
    logic supply_disable_n;
    logic fault_clear;
  } board_out_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HIGH,
    PH_DEAD_LO,
    PH_LOW
  } phase_t;

endpackage

/* verilog/temp_freq_meter.sv */
// Purpose: counts rising edges of the frequency-encoded temperature output per gate window
// Assumes: temperature output already synchronous to clk_sys
// Notes:   one result per one-second window, so the count reads in hertz
`timescale 1ns/1ns
`include "gate_ctl_regs.svh"
module temp_freq_meter
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        temp_in,
  output logic [15:0]      freq_hz,
  output logic             done
);

  typedef struct packed {
    logic        prev;
    logic [24:0] gate;
    logic [15:0] cnt;
    logic [15:0] res;
    logic        done;
  } meter_t;

  meter_t s_q;
  meter_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.prev = temp_in;
    s_d.done = 1'b0;
    if (temp_in && !s_q.prev && s_q.cnt != 16'hFFFF)
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    if (s_q.gate == 25'(`GC_TEMP_GATE_CYC - 1))
    begin
      s_d.gate = '0;
      s_d.res  = s_d.cnt;
      s_d.cnt  = '0;
      s_d.done = 1'b1;
    end
    else
    begin
      s_d.gate = s_q.gate + 25'h0000001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign freq_hz = s_q.res;
  assign done    = s_q.done;

endmodule

/* verilog/gate_ctl.sv */
// Purpose: inverter-side controller that drives the half-bridge gate driver board pins
// Assumes: board pins synchronous to clk_sys; software uses APB
// Notes:   generates complementary switching with dead time, sequences supplies, clears faults
// Functional notes
// RQ1 - drive both commands as differential pairs
// RQ2 - board blocks overlap; never command both
// RQ3 - insert own dead time between commands
// RQ4 - fault pin low means a channel fault
// RQ5 - board lights per-channel indicators
// RQ6 - board holds gate low in undervoltage
// RQ7 - undervoltage fault clears without clear pulse
// RQ8 - board soft-shuts channel on overcurrent
// RQ9 - overcurrent fault latched until cleared
// RQ10 - clear pulse high at least 500 ns
// RQ11 - board blocks gate during any fault
// RQ12 - switching enable low forces gates low
// RQ13 - fault and temperature work while disabled
// RQ14 - supply disable low turns supplies off
// RQ15 - keep supplies off until system ready
// RQ16 - temperature returned as frequency
// RQ17 - temperature is 50% duty square wave
// RQ18 - gates follow commands when enabled, faultless
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "gate_ctl_regs.svh"
module gate_ctl
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        fault_pos,
  input  wire logic        fault_neg,
  input  wire logic        temp_freq_pos,
  input  wire logic        temp_freq_neg,
  output logic             high_side_cmd_pos,
  output logic             high_side_cmd_neg,
  output logic             low_side_cmd_pos,
  output logic             low_side_cmd_neg,
  output logic             sw_enable,
  output logic             supply_disable_n,
  output logic             fault_clear,
  output logic             irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0]                ctrl;
    logic [15:0]               period;
    logic [15:0]               duty;
    logic [15:0]               dead;
    logic [15:0]               cnt;
    gate_ctl_pkg::phase_t      phase;
    logic                      fault_seen;
    logic [5:0]                clr_cnt;
    logic [`GC_IRQ_W-1:0]      irq_stat;
    logic [`GC_IRQ_W-1:0]      irq_en;
    logic [15:0]               temp;
    gate_ctl_pkg::apb_rsp_t    rsp;
    gate_ctl_pkg::board_out_t  pins;
    logic                      irq;
  } ctl_t;

  ctl_t s_q;
  ctl_t s_d;

  logic        fault_ok;
  logic        temp_lvl;
  logic [15:0] temp_hz;
  logic        temp_done;
  logic        wr_acc;
  logic        rd_acc;
  logic        hs_on;
  logic        ls_on;
  logic [`GC_IRQ_W-1:0] ev;

  // RQ4 fault reads high (pos above neg) only when neither channel faults
  assign fault_ok = fault_pos & ~fault_neg;
  // RQ16 temperature square wave decoded from both lines, high while pos is high and neg is low
  assign temp_lvl = temp_freq_pos & ~temp_freq_neg;
  // one wait state: the first access edge raises pready and loads read data,
  // the edge that samples pready high commits a write, so it never lands twice
  assign wr_acc   = psel & penable & pwrite & s_q.rsp.pready;
  assign rd_acc   = psel & penable & ~pwrite & ~s_q.rsp.pready;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `GC_CTRL_OFS) || (a == `GC_PERIOD_OFS) || (a == `GC_DUTY_OFS)
              || (a == `GC_DEAD_OFS) || (a == `GC_STATUS_OFS) || (a == `GC_IRQ_STAT_OFS)
              || (a == `GC_IRQ_EN_OFS) || (a == `GC_IRQ_CLR_OFS) || (a == `GC_TEMP_OFS)
              || (a == `GC_CLEAR_OFS);
  endfunction

  // RQ17 a half period measures the same either way; rising edges suffice
  temp_freq_meter u_meter
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .temp_in (temp_lvl),
    .freq_hz (temp_hz),
    .done    (temp_done)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.rsp    = '0;
    hs_on      = 1'b0;
    ls_on      = 1'b0;
    ev         = '0;

    // ****************************************
    // pwm phase machine: high, dead, low, dead
    // ****************************************
    // a stop or a fault drops straight to idle, so both commands fall next edge
    if (!s_q.ctrl[`GC_CTRL_RUN] || !fault_ok)
    begin
      s_d.phase = gate_ctl_pkg::PH_IDLE;
      s_d.cnt   = '0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
      case (s_q.phase)
        // RQ3 idle is the dead gap after low, and before the first high as well
        gate_ctl_pkg::PH_IDLE:
        begin
          if (s_q.cnt >= s_q.dead)
          begin
            s_d.phase = gate_ctl_pkg::PH_HIGH;
            s_d.cnt   = '0;
          end
        end
        gate_ctl_pkg::PH_HIGH:
        begin
          if (s_q.cnt >= s_q.duty)
          begin
            s_d.phase = gate_ctl_pkg::PH_DEAD_LO;
            s_d.cnt   = '0;
          end
        end
        // RQ3 dead time after high before low
        gate_ctl_pkg::PH_DEAD_LO:
        begin
          if (s_q.cnt >= s_q.dead)
          begin
            s_d.phase = gate_ctl_pkg::PH_LOW;
            s_d.cnt   = '0;
          end
        end
        gate_ctl_pkg::PH_LOW:
        begin
          // RQ3 the low span ends early by dead, then idle gives dead before high
          if (s_q.cnt + s_q.dead + s_q.duty >= s_q.period)
          begin
            s_d.phase = gate_ctl_pkg::PH_IDLE;
            s_d.cnt   = '0;
          end
        end
        default:
        begin
          s_d.phase = gate_ctl_pkg::PH_IDLE;
        end
      endcase
    end

    // ****************************************
    // board pins
    // ****************************************
    // RQ2 at most one command high by construction
    hs_on = (s_d.phase == gate_ctl_pkg::PH_HIGH);
    ls_on = (s_d.phase == gate_ctl_pkg::PH_LOW);
    // RQ1 complementary differential drive
    s_d.pins.high_side_cmd_pos = hs_on;
    s_d.pins.high_side_cmd_neg = ~hs_on;
    s_d.pins.low_side_cmd_pos  = ls_on;
    s_d.pins.low_side_cmd_neg  = ~ls_on;
    // RQ12 enable low makes the board force gates low
    s_d.pins.sw_enable         = s_q.ctrl[`GC_CTRL_SW_EN];
    // RQ15 supplies stay off until software sets supply_on
    s_d.pins.supply_disable_n  = s_q.ctrl[`GC_CTRL_SUPPLY_ON];

    // ****************************************
    // fault clear pulse
    // ****************************************
    // a write during a pulse restarts it; the board only asks for a minimum width
    // RQ10 clear pulse held for the full minimum count
    if (s_q.clr_cnt != '0)
    begin
      s_d.clr_cnt = s_q.clr_cnt - 6'h01;
    end
    if (wr_acc && paddr == `GC_CLEAR_OFS && pwdata[0])
    begin
      s_d.clr_cnt = 6'(`GC_CLR_PULSE_CYC);
    end
    s_d.pins.fault_clear = (s_d.clr_cnt != '0);

    // ****************************************
    // interrupt events
    // ****************************************
    // events; a set in the same cycle as a clear wins
    s_d.fault_seen = ~fault_ok;
    ev[`GC_IRQ_FAULT_SET]  = ~fault_ok & ~s_q.fault_seen;
    ev[`GC_IRQ_FAULT_GONE] = fault_ok & s_q.fault_seen;
    ev[`GC_IRQ_TEMP]       = temp_done;
    // temp holds the last full window, never a partial count
    if (temp_done)
    begin
      s_d.temp = temp_hz;
    end

    // ****************************************
    // apb slave, one wait state
    // ****************************************
    s_d.rsp.pready = psel & penable & ~s_q.rsp.pready;
    // unmapped addresses answer with pslverr; reads of them return zero
    if (psel && penable && !s_q.rsp.pready && !addr_known(paddr))
    begin
      s_d.rsp.pslverr = 1'b1;
    end
    if (wr_acc)
    begin
      case (paddr)
        `GC_CTRL_OFS:    s_d.ctrl    = pwdata[2:0];
        `GC_PERIOD_OFS:  s_d.period  = pwdata[15:0];
        `GC_DUTY_OFS:    s_d.duty    = pwdata[15:0];
        // a zero dead time is raised to the minimum; overlap blocking alone is not enough
        `GC_DEAD_OFS:    s_d.dead    = (pwdata[15:0] == '0) ? `GC_DEAD_MIN : pwdata[15:0];
        `GC_IRQ_EN_OFS:  s_d.irq_en  = pwdata[`GC_IRQ_W-1:0];
        `GC_IRQ_CLR_OFS: s_d.irq_stat = s_q.irq_stat & ~pwdata[`GC_IRQ_W-1:0];
        default:         s_d.ctrl    = s_d.ctrl;
      endcase
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    if (rd_acc)
    begin
      case (paddr)
        `GC_CTRL_OFS:     s_d.rsp.prdata = {29'h0, s_q.ctrl};
        `GC_PERIOD_OFS:   s_d.rsp.prdata = {16'h0, s_q.period};
        `GC_DUTY_OFS:     s_d.rsp.prdata = {16'h0, s_q.duty};
        `GC_DEAD_OFS:     s_d.rsp.prdata = {16'h0, s_q.dead};
        `GC_STATUS_OFS:   s_d.rsp.prdata = {29'h0, (s_q.phase != gate_ctl_pkg::PH_IDLE),
                                            (s_q.clr_cnt != '0), ~fault_ok};
        `GC_IRQ_STAT_OFS: s_d.rsp.prdata = {29'h0, s_q.irq_stat};
        `GC_IRQ_EN_OFS:   s_d.rsp.prdata = {29'h0, s_q.irq_en};
        `GC_TEMP_OFS:     s_d.rsp.prdata = {16'h0, s_q.temp};
        default:          s_d.rsp.prdata = 32'h00000000;
      endcase
    end
    // level irq from next state, so it changes in the same cycle as the status bits
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q        <= '0;
      s_q.ctrl   <= 3'(`GC_CTRL_RESET);
      s_q.period <= `GC_PERIOD_RESET;
      s_q.duty   <= `GC_DUTY_RESET;
      s_q.dead   <= `GC_DEAD_RESET;
      s_q.phase  <= gate_ctl_pkg::PH_IDLE;
      // the pairs idle with the negative line high, so each reads off
      s_q.pins.high_side_cmd_neg <= 1'b1;
      s_q.pins.low_side_cmd_neg  <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready            = s_q.rsp.pready;
  assign prdata            = s_q.rsp.prdata;
  assign pslverr           = s_q.rsp.pslverr;
  assign high_side_cmd_pos = s_q.pins.high_side_cmd_pos;
  assign high_side_cmd_neg = s_q.pins.high_side_cmd_neg;
  assign low_side_cmd_pos  = s_q.pins.low_side_cmd_pos;
  assign low_side_cmd_neg  = s_q.pins.low_side_cmd_neg;
  assign sw_enable         = s_q.pins.sw_enable;
  assign supply_disable_n  = s_q.pins.supply_disable_n;
  assign fault_clear       = s_q.pins.fault_clear;
  assign irq               = s_q.irq;

endmodule

/* verif/gate_ctl_assertions.sv */
// Purpose: port-level assertions for gate_ctl
// Assumes: one clock domain, rst_n async active low
// Notes:   bound from the bench top file
`timescale 1ns/1ns
`include "gate_ctl_regs.svh"
module gate_ctl_assertions
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_pos,
  input wire logic fault_neg,
  input wire logic high_side_cmd_pos,
  input wire logic high_side_cmd_neg,
  input wire logic low_side_cmd_pos,
  input wire logic low_side_cmd_neg,
  input wire logic fault_clear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [4:0] clr_len;
  // pulse length is counted here; a long repetition would slow the tools
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clr_len <= 5'h00;
    end
    else if (!fault_clear)
    begin
      clr_len <= 5'h00;
    end
    else if (clr_len != 5'h1F)
    begin
      clr_len <= clr_len + 5'h01;
    end
  end
  // ****
  // commands
  // ****
  a_no_overlap: assert property (!(high_side_cmd_pos && low_side_cmd_pos))
    else $error("both commands high");
  a_high_pair: assert property (high_side_cmd_neg == !high_side_cmd_pos)
    else $error("high pair not complementary");
  a_low_pair: assert property (low_side_cmd_neg == !low_side_cmd_pos)
    else $error("low pair not complementary");
  a_dead_after_high: assert property ($fell(high_side_cmd_pos) |-> !low_side_cmd_pos [*2])
    else $error("dead gap after high too short");
  a_dead_after_low: assert property ($fell(low_side_cmd_pos) |-> !high_side_cmd_pos [*2])
    else $error("dead gap after low too short");
  // board fault forbids commands from the next cycle on
  a_fault_idles: assert property (!(fault_pos && !fault_neg) |=> !high_side_cmd_pos && !low_side_cmd_pos)
    else $error("command during fault");
  a_clear_width: assert property ($fell(fault_clear) |-> clr_len == 5'(`GC_CLR_PULSE_CYC))
    else $error("clear pulse not 10 cycles");
  a_clear_max: assert property (clr_len <= 5'(`GC_CLR_PULSE_CYC))
    else $error("clear pulse longer than 10 cycles");
  // ****
  // register bus
  // ****
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_high: cover property ($rose(high_side_cmd_pos));
  c_low: cover property ($rose(low_side_cmd_pos));
  c_clear: cover property ($rose(fault_clear));
  c_err: cover property (pslverr);
endmodule

/* verif/board_model.sv */
// Purpose: behavioural gate driver board facing gate_ctl
// Assumes: pins synchronous to clk_sys
// Notes:   overcurrent and undervoltage are ordered by the bench
`timescale 1ns/1ns
module board_model
#(
  parameter logic [3:0] TEMP_HALF = 4'h7
)
(
  input  wire logic clk_sys,
  input  wire logic high_side_cmd_pos,
  input  wire logic high_side_cmd_neg,
  input  wire logic low_side_cmd_pos,
  input  wire logic low_side_cmd_neg,
  input  wire logic sw_enable,
  input  wire logic supply_disable_n,
  input  wire logic fault_clear,
  input  wire logic oc_req,
  input  wire logic uv_req,
  output logic      fault_pos,
  output logic      fault_neg,
  output logic      temp_freq_pos,
  output logic      temp_freq_neg,
  output logic      gate_high,
  output logic      gate_low
);
  logic       oc_q = 1'b0;
  logic       tmp_q = 1'b0;
  logic [3:0] clr_n = 4'h0;
  logic [3:0] tmp_n = 4'h0;
  logic       fault, hs, ls;
  assign hs = high_side_cmd_pos & ~high_side_cmd_neg;
  assign ls = low_side_cmd_pos & ~low_side_cmd_neg;
  // combined fault, indicators share it, supplies off is lockout
  assign fault = oc_q | uv_req | ~supply_disable_n;
  assign fault_pos = ~fault;
  assign fault_neg = fault;
  assign gate_high = hs & ~ls & sw_enable & ~fault;
  assign gate_low = ls & ~hs & sw_enable & ~fault;
  // latch released only by a clear held 10 cycles
  always @(posedge clk_sys)
  begin
    clr_n <= fault_clear ? clr_n + 4'h1 : 4'h0;
    if (oc_req)
      oc_q <= 1'b1;
    else if (fault_clear && clr_n == 4'h9)
      oc_q <= 1'b0;
  end
  always @(posedge clk_sys)
  begin
    tmp_n <= (tmp_n == TEMP_HALF) ? 4'h0 : tmp_n + 4'h1;
    if (tmp_n == TEMP_HALF)
      tmp_q <= ~tmp_q;
  end
  assign temp_freq_pos = tmp_q;
  assign temp_freq_neg = ~tmp_q;
endmodule

/* verif/gate_ctl_tb.sv */
// Purpose: self-checking bench of gate_ctl with a board model
// Assumes: 20 MHz clk_sys, APB answer in two access cycles
// Notes:   the one-second temperature window is too long to reach here
`timescale 1ns/1ns
`include "gate_ctl_regs.svh"
module gate_ctl_tb;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fault_pos, fault_neg, temp_freq_pos, temp_freq_neg, irq;
  logic        high_side_cmd_pos, high_side_cmd_neg, low_side_cmd_pos, low_side_cmd_neg;
  logic        sw_enable, supply_disable_n, fault_clear, oc_req, uv_req;
  int          fails, compares, hi, gap, d, t;
  gate_ctl gate_ctl_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fault_pos(fault_pos), .fault_neg(fault_neg), .temp_freq_pos(temp_freq_pos), .temp_freq_neg(temp_freq_neg),
    .high_side_cmd_pos(high_side_cmd_pos), .high_side_cmd_neg(high_side_cmd_neg),
    .low_side_cmd_pos(low_side_cmd_pos), .low_side_cmd_neg(low_side_cmd_neg), .sw_enable(sw_enable),
    .supply_disable_n(supply_disable_n), .fault_clear(fault_clear), .irq(irq));
  board_model board_model_i (.clk_sys(clk_sys), .high_side_cmd_pos(high_side_cmd_pos),
    .high_side_cmd_neg(high_side_cmd_neg), .low_side_cmd_pos(low_side_cmd_pos),
    .low_side_cmd_neg(low_side_cmd_neg), .sw_enable(sw_enable), .supply_disable_n(supply_disable_n),
    .fault_clear(fault_clear), .oc_req(oc_req), .uv_req(uv_req), .fault_pos(fault_pos), .fault_neg(fault_neg),
    .temp_freq_pos(temp_freq_pos), .temp_freq_neg(temp_freq_neg), .gate_high(), .gate_low());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // bus and pin helpers
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      fails++;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd & mask, exp);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // first full high phase, then the both-low gap up to the low phase
  task automatic measure;
    hi = 0;
    gap = 0;
    while (high_side_cmd_pos !== 1'b1 && hi < 5000)
    begin
      @(posedge clk_sys);
      hi++;
    end
    hi = 0;
    while (high_side_cmd_pos === 1'b1 && hi < 5000)
    begin
      @(posedge clk_sys);
      hi++;
    end
    while (low_side_cmd_pos !== 1'b1 && gap < 5000)
    begin
      @(posedge clk_sys);
      gap++;
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    pause(60000);
    fails++;
    test_done;
  end
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, oc_req, uv_req} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    compares = 0;
    d = $urandom(99072);
    pause(2);
    rst_n <= 1'b1;
    check(32'({sw_enable, supply_disable_n, fault_clear, irq, high_side_cmd_neg, low_side_cmd_neg}), 32'h3);
    rdchk(`GC_CTRL_OFS, 32'hFFFFFFFF, 32'(`GC_CTRL_RESET));
    rdchk(`GC_PERIOD_OFS, 32'hFFFFFFFF, 32'(`GC_PERIOD_RESET));
    rdchk(`GC_DUTY_OFS, 32'hFFFFFFFF, 32'(`GC_DUTY_RESET));
    rdchk(`GC_DEAD_OFS, 32'hFFFFFFFF, 32'(`GC_DEAD_RESET));
    rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, `GC_CTRL_OFS, 32'h2);
    pause(2);
    check(32'({supply_disable_n, sw_enable}), 32'h2);
    for (int k = 0; k < 3; k++)
    begin
      d = 4 + $urandom % 12;
      t = (k == 0) ? 0 : 1 + $urandom % 6;
      apb(1'b1, `GC_CTRL_OFS, 32'h2);
      apb(1'b1, `GC_PERIOD_OFS, 32'h000000C8);
      apb(1'b1, `GC_DUTY_OFS, 32'(d));
      apb(1'b1, `GC_DEAD_OFS, 32'(t));
      t = (t == 0) ? 1 : t;
      rdchk(`GC_DEAD_OFS, 32'hFFFFFFFF, 32'(t));
      apb(1'b1, `GC_CTRL_OFS, 32'h7);
      measure;
      check(32'(hi), 32'(d + 1));
      check(32'(gap), 32'(t + 1));
    end
    apb(1'b1, `GC_IRQ_CLR_OFS, 32'h7);
    apb(1'b1, `GC_IRQ_EN_OFS, 32'h1);
    oc_req <= 1'b1;
    pause(1);
    oc_req <= 1'b0;
    pause(4);
    check(32'(irq), 32'h1);
    rdchk(`GC_STATUS_OFS, 32'h1, 32'h1);
    apb(1'b1, `GC_CLEAR_OFS, 32'h1);
    pause(16);
    rdchk(`GC_STATUS_OFS, 32'h1, 32'h0);
    rdchk(`GC_IRQ_STAT_OFS, 32'h3, 32'h3);
    apb(1'b1, `GC_IRQ_CLR_OFS, 32'h1);
    pause(2);
    check(32'(irq), 32'h0);
    apb(1'b1, `GC_IRQ_EN_OFS, 32'h0);
    uv_req <= 1'b1;
    pause(4);
    check(32'(irq), 32'h0);
    rdchk(`GC_STATUS_OFS, 32'h1, 32'h1);
    uv_req <= 1'b0;
    pause(4);
    rdchk(`GC_STATUS_OFS, 32'h1, 32'h0);
    apb(1'b1, `GC_IRQ_EN_OFS, 32'h2);
    pause(2);
    check(32'(irq), 32'h1);
    apb(1'b1, `GC_IRQ_CLR_OFS, 32'h7);
    pause(2);
    check(32'(irq), 32'h0);
    test_done;
  end
endmodule
bind gate_ctl gate_ctl_assertions gate_ctl_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .fault_pos(fault_pos), .fault_neg(fault_neg),
  .high_side_cmd_pos(high_side_cmd_pos), .high_side_cmd_neg(high_side_cmd_neg),
  .low_side_cmd_pos(low_side_cmd_pos), .low_side_cmd_neg(low_side_cmd_neg), .fault_clear(fault_clear));
